//--- cds_pkg.sv
package cds_pkg;

	// Register numbers and selects of the coprocessor move space
	localparam logic [4:0] REGN_FEATURE  = 5'h10;
	localparam logic [4:0] REGN_LINKED_LOAD_ADDRESS   = 5'h11;
	localparam logic [4:0] REGN_CTX_EXT  = 5'h14;
	localparam logic [4:0] REGN_DIAG     = 5'h16;
	localparam logic [4:0] REGN_DEBUG    = 5'h17;
	localparam logic [4:0] REGN_DRET     = 5'h18;
	localparam logic [4:0] REGN_PERF     = 5'h19;
	localparam logic [2:0] SEL_FEATURE   = 3'h3;
	localparam logic [2:0] SEL_ZERO      = 3'h0;

	// Capability flag positions
	localparam int FEAT_MORE_BIT  = 31;
	localparam int FEAT_DSP_BIT   = 10;
	localparam int FEAT_LPA_BIT   = 7;
	localparam int FEAT_EIC_BIT   = 6;
	localparam int FEAT_VINT_BIT  = 5;
	localparam int FEAT_SPAGE_BIT = 4;
	localparam int FEAT_MT_BIT    = 2;
	localparam int FEAT_CARD_BIT  = 1;
	localparam int FEAT_TRACE_BIT = 0;

	// Extended context layout
	localparam int CTX_VPN2_LSB   = 4;
	localparam int CTX_VPN2_MSB   = 38;
	localparam int CTX_REGION_LSB = 39;
	localparam int CTX_REGION_MSB = 40;
	localparam int CTX_BASE_LSB   = 41;
	localparam int VA_VPN2_LSB    = 13;
	localparam int VA_VPN2_MSB    = 47;
	localparam int VA_REGION_LSB  = 62;

	// Diagnostic control layout
	localparam int DIAG_RAS_BIT   = 0;
	localparam int DIAG_BTB_BIT   = 1;
	localparam int DIAG_ITLB_BIT  = 2;
	localparam int DIAG_SFET_BIT  = 3;
	localparam int DIAG_SISS_BIT  = 4;
	localparam int DIAG_WISS_BIT  = 5;
	localparam int DIAG_WCAC_BIT  = 6;

	// Debug control/status layout
	localparam int DBG_DBD_BIT    = 31;
	localparam int DBG_DM_BIT     = 30;
	localparam int DBG_DEBUG_SEGMENT_ABSENT_BIT  = 29;
	localparam int DBG_DEBUG_LOADSTORE_TARGET_BIT   = 28;
	localparam int DBG_CNTDM_BIT  = 25;
	localparam int DBG_VER_LSB    = 15;
	localparam int DBG_VER_MSB    = 17;
	localparam int DBG_CODE_LSB   = 10;
	localparam int DBG_CODE_MSB   = 14;
	localparam int DBG_SINGLE_STEP_UNSUPPORTED_BIT  = 9;
	localparam int DBG_SST_BIT    = 8;
	localparam int DBG_DEBUG_IRQ_STATUS_BIT   = 5;
	localparam int DBG_DIB_BIT    = 4;
	localparam int DBG_DATA_BREAK_STATUS_BIT   = 3;
	localparam int DBG_DBP_BIT    = 1;
	localparam int DBG_DSS_BIT    = 0;
	localparam logic [31:0] DBG_RESET   = 32'h02018000;
	localparam logic [2:0]  DBG_VER_1_2 = 3'h0;
	localparam logic [2:0]  DBG_VER_2_5 = 3'h1;
	localparam logic [2:0]  DBG_VER_2_6 = 3'h2;
	localparam logic [2:0]  DBG_VER_3_1 = 3'h3;
	localparam logic [63:0] BRANCH_STEP = 64'h0000000000000004;

	// Performance control layout
	localparam int PC_MORE_BIT    = 31;
	localparam int PC_WIDE_BIT    = 30;
	localparam int PC_EVT_LSB     = 5;
	localparam int PC_EVT_MSB     = 8;
	localparam int PC_IE_BIT      = 4;
	localparam int PC_USER_BIT    = 3;
	localparam int PC_SUPER_BIT   = 2;
	localparam int PC_KERN_BIT    = 1;
	localparam int PC_EXL_BIT     = 0;
	localparam logic [31:0] PC0_RESET = 32'hC0000000;
	localparam logic [31:0] PC1_RESET = 32'h40000000;
	localparam logic [31:0] PC_WR_MASK = 32'h000001FF;

	// Privilege level encodings
	localparam logic [1:0] PRIV_KERNEL = 2'h0;
	localparam logic [1:0] PRIV_SUPER  = 2'h1;
	localparam logic [1:0] PRIV_USER   = 2'h2;

endpackage

//--- cds_sysregs.sv
`timescale 1ns/1ps

module cds_sysregs #(
	parameter bit   HAS_DSP      = 1'b0,
	parameter bit   HAS_LPA      = 1'b1,
	parameter bit   HAS_EIC      = 1'b0,
	parameter bit   HAS_VINT     = 1'b1,
	parameter bit   HAS_SPAGE    = 1'b0,
	parameter bit   HAS_MT       = 1'b0,
	parameter bit   HAS_CARD     = 1'b0,
	parameter bit   HAS_TRACE    = 1'b0,
	parameter bit   COUNT_IN_DBG = 1'b1,
	parameter int   PERF_W       = 64,
	parameter int   EVT_N        = 16
) (
	// Clock and reset
	input  wire logic        i_core_clk,
	input  wire logic        i_rst_n,
	// Coprocessor move port
	input  wire logic        i_cop_wr_en,
	input  wire logic        i_cop_rd_en,
	input  wire logic [4:0]  i_cop_reg,
	input  wire logic [2:0]  i_cop_sel,
	input  wire logic [63:0] i_cop_wr_data,
	output logic [63:0]      o_cop_rd_data,
	output logic             o_cop_rd_valid,
	// Load-linked and exception return
	input  wire logic        i_ll_valid,
	input  wire logic [63:0] i_ll_pfn,
	input  wire logic        i_eret,
	// Translation fault
	input  wire logic        i_tlb_exc,
	input  wire logic [63:0] i_tlb_vaddr,
	// Debug exception events
	input  wire logic        i_dbg_exc,
	input  wire logic        i_dbg_precise,
	input  wire logic        i_dbg_int,
	input  wire logic        i_dbg_ibreak,
	input  wire logic        i_dbg_dbreak,
	input  wire logic        i_dbg_bp,
	input  wire logic        i_dbg_sstep,
	input  wire logic        i_exc_in_dbg,
	input  wire logic [4:0]  i_exc_code,
	input  wire logic        i_exc_dslot,
	input  wire logic [63:0] i_exc_pc,
	input  wire logic        i_dbg_return,
	// Processor state qualifiers and events
	input  wire logic [1:0]  i_privilege_level,
	input  wire logic        i_exception_level,
	input  wire logic        i_error_level,
	input  wire logic [EVT_N-1:0] i_perf_event0,
	input  wire logic [EVT_N-1:0] i_perf_event1,
	// Control outputs
	output logic             o_itlb_flush,
	output logic             o_btb_flush,
	output logic             o_ras_disable,
	output logic [3:0]       o_unlimit,
	output logic             o_debug_mode_flag,
	output logic             o_single_step_enable,
	output logic             o_debug_loadstore_target,
	output logic             o_count_run_in_debug,
	output logic             o_perf_irq,
	output logic             o_perf_pending
);
	import cds_pkg::*;

	if (PERF_W != 64) begin : g_chk_w
		$error("cds_sysregs: counters must be 64 bits");
	end
	if (EVT_N != 16) begin : g_chk_e
		$error("cds_sysregs: event select is four bits, need 16 events");
	end
	// The reset value carries the count-in-debug bit, so both must agree or it flips after reset
	if (DBG_RESET[DBG_CNTDM_BIT] != COUNT_IN_DBG) begin : g_chk_c
		$error("cds_sysregs: count-in-debug flag disagrees with debug reset value");
	end

	logic [63:0] ll_q, ll_d;
	logic [63:0] ctx_q, ctx_d;
	logic [6:0]  diag_q, diag_d;
	logic [31:0] dbg_q, dbg_d;
	logic [63:0] dret_q, dret_d;
	logic [63:0] rd_q, rd_d;
	logic        rd_vld_q, rd_vld_d;
	logic [31:0] pctl_q [2];
	logic [31:0] pctl_d [2];
	logic [63:0] pcnt_q [2];
	logic [63:0] pcnt_d [2];
	logic [31:0] feat;
	logic [31:0] dbg_view;
	logic        wr_feat;
	logic        wr_ctx;
	logic        wr_diag;
	logic        wr_dbg;
	logic        wr_dret;
	logic        mode_kern;
	logic        mode_super;
	logic        mode_user;
	logic        mode_exl;

	// Capability flags are fixed by build options
	always_comb begin
		feat                 = 32'h00000000;
		feat[FEAT_DSP_BIT]   = HAS_DSP;
		feat[FEAT_LPA_BIT]   = HAS_LPA;
		feat[FEAT_EIC_BIT]   = HAS_EIC;
		feat[FEAT_VINT_BIT]  = HAS_VINT;
		feat[FEAT_SPAGE_BIT] = HAS_SPAGE;
		feat[FEAT_MT_BIT]    = HAS_MT;
		feat[FEAT_CARD_BIT]  = HAS_CARD;
		feat[FEAT_TRACE_BIT] = HAS_TRACE;
	end

	assign wr_feat = i_cop_wr_en && (i_cop_reg == REGN_FEATURE) && (i_cop_sel == SEL_FEATURE);
	assign wr_ctx  = i_cop_wr_en && (i_cop_reg == REGN_CTX_EXT) && (i_cop_sel == SEL_ZERO);
	assign wr_diag = i_cop_wr_en && (i_cop_reg == REGN_DIAG) && (i_cop_sel == SEL_ZERO);
	assign wr_dbg  = i_cop_wr_en && (i_cop_reg == REGN_DEBUG) && (i_cop_sel == SEL_ZERO);
	assign wr_dret = i_cop_wr_en && (i_cop_reg == REGN_DRET) && (i_cop_sel == SEL_ZERO);

	// Linked address, extended context, diagnostic
	always_comb begin
		ll_d   = ll_q;
		ctx_d  = ctx_q;
		diag_d = diag_q;
		// Hardware load beats the clear from a same-cycle return
		if (i_ll_valid) begin
			ll_d = i_ll_pfn;
		end else if (i_eret) begin
			ll_d = 64'h0000000000000000;
		end
		if (wr_ctx) begin
			ctx_d[63:CTX_BASE_LSB] = i_cop_wr_data[63:CTX_BASE_LSB];
		end
		// Fault capture fills the VPN2 and region bits, which a software write never touches
		if (i_tlb_exc) begin
			ctx_d[CTX_VPN2_MSB:CTX_VPN2_LSB] = i_tlb_vaddr[VA_VPN2_MSB:VA_VPN2_LSB];
			ctx_d[CTX_REGION_MSB:CTX_REGION_LSB] = i_tlb_vaddr[63:VA_REGION_LSB];
		end
		ctx_d[CTX_VPN2_LSB-1:0] = '0;
		if (wr_diag) begin
			diag_d[DIAG_RAS_BIT]  = i_cop_wr_data[DIAG_RAS_BIT];
			diag_d[DIAG_SFET_BIT] = i_cop_wr_data[DIAG_SFET_BIT];
			diag_d[DIAG_SISS_BIT] = i_cop_wr_data[DIAG_SISS_BIT];
			diag_d[DIAG_WISS_BIT] = i_cop_wr_data[DIAG_WISS_BIT];
			diag_d[DIAG_WCAC_BIT] = i_cop_wr_data[DIAG_WCAC_BIT];
		end
		// Flush bits are one-shot and never stored
		diag_d[DIAG_BTB_BIT]  = 1'b0;
		diag_d[DIAG_ITLB_BIT] = 1'b0;
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			ll_q   <= 64'h0000000000000000;
			ctx_q  <= 64'h0000000000000000;
			diag_q <= 7'h00;
		end else begin
			ll_q   <= ll_d;
			ctx_q  <= ctx_d;
			diag_q <= diag_d;
		end
	end

	// Flush strobes are registered pulses one cycle after the write
	logic itlb_flush_q;
	logic itlb_flush_d;
	logic btb_flush_q;
	logic btb_flush_d;
	always_comb begin
		itlb_flush_d = wr_diag && i_cop_wr_data[DIAG_ITLB_BIT];
		btb_flush_d  = wr_diag && i_cop_wr_data[DIAG_BTB_BIT];
	end
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			itlb_flush_q <= 1'b0;
			btb_flush_q  <= 1'b0;
		end else begin
			itlb_flush_q <= itlb_flush_d;
			btb_flush_q  <= btb_flush_d;
		end
	end

	// Debug control/status and debug return address
	always_comb begin
		dbg_d  = dbg_q;
		dret_d = dret_q;
		if (wr_dbg) begin
			dbg_d[DBG_DEBUG_LOADSTORE_TARGET_BIT] = i_cop_wr_data[DBG_DEBUG_LOADSTORE_TARGET_BIT];
			dbg_d[DBG_SST_BIT]  = i_cop_wr_data[DBG_SST_BIT];
		end
		if (wr_dret) begin
			dret_d = i_cop_wr_data;
		end
		// Hardware-owned fields move only on these events
		if (i_dbg_exc) begin
			dbg_d[DBG_DBD_BIT]  = i_exc_dslot;
			dbg_d[DBG_DM_BIT]   = 1'b1;
			dbg_d[DBG_DEBUG_IRQ_STATUS_BIT] = i_dbg_int;
			dbg_d[DBG_DIB_BIT]  = i_dbg_ibreak;
			dbg_d[DBG_DATA_BREAK_STATUS_BIT] = i_dbg_dbreak;
			dbg_d[DBG_DBP_BIT]  = i_dbg_bp;
			dbg_d[DBG_DSS_BIT]  = i_dbg_sstep;
		end else if (i_exc_in_dbg && dbg_q[DBG_DM_BIT]) begin
			dbg_d[DBG_DBD_BIT] = i_exc_dslot;
			dbg_d[DBG_CODE_MSB:DBG_CODE_LSB] = i_exc_code;
		end else if (i_dbg_return) begin
			dbg_d[DBG_DM_BIT] = 1'b0;
		end
		if ((i_dbg_exc && i_dbg_precise) || (i_exc_in_dbg && dbg_q[DBG_DM_BIT])) begin
			dret_d = i_exc_dslot ? (i_exc_pc - BRANCH_STEP) : i_exc_pc;
		end
		dbg_d[DBG_CNTDM_BIT]             = COUNT_IN_DBG;
		dbg_d[DBG_VER_MSB:DBG_VER_LSB]   = DBG_VER_3_1;
		dbg_d[DBG_DEBUG_SEGMENT_ABSENT_BIT]             = 1'b0;
		dbg_d[DBG_SINGLE_STEP_UNSUPPORTED_BIT]             = 1'b0;
		dbg_d[27:26]                     = 2'h0;
		dbg_d[24:18]                     = 7'h00;
		dbg_d[7:6]                       = 2'h0;
		dbg_d[2]                         = 1'b0;
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			dbg_q  <= DBG_RESET;
			dret_q <= 64'h0000000000000000;
		end else begin
			dbg_q  <= dbg_d;
			dret_q <= dret_d;
		end
	end

	// Outside debug mode the other fields are stale, so hide them
	always_comb begin
		dbg_view = 32'h00000000;
		if (dbg_q[DBG_DM_BIT]) begin
			dbg_view = dbg_q;
		end else begin
			dbg_view[DBG_DM_BIT]              = dbg_q[DBG_DM_BIT];
			dbg_view[DBG_VER_MSB:DBG_VER_LSB] = dbg_q[DBG_VER_MSB:DBG_VER_LSB];
		end
	end

	// Mode qualifiers shared by both counters
	always_comb begin
		mode_kern  = (i_privilege_level == PRIV_KERNEL) && !i_exception_level && !i_error_level;
		mode_super = (i_privilege_level == PRIV_SUPER) && !i_exception_level && !i_error_level;
		mode_user  = (i_privilege_level == PRIV_USER) && !i_exception_level && !i_error_level;
		mode_exl   = i_exception_level && !i_error_level;
	end

	// Performance counter groups
	for (genvar g = 0; g < 2; g++) begin : g_perf
		logic [EVT_N-1:0] evts;
		logic             wr_ctl;
		logic             wr_cnt;
		logic             qual;
		logic             hit;
		assign evts   = (g == 0) ? i_perf_event0 : i_perf_event1;
		assign wr_ctl = i_cop_wr_en && (i_cop_reg == REGN_PERF) && (i_cop_sel == 3'(2 * g));
		assign wr_cnt = i_cop_wr_en && (i_cop_reg == REGN_PERF) && (i_cop_sel == 3'(2 * g + 1));
		assign qual   = (pctl_q[g][PC_KERN_BIT] && mode_kern)
			|| (pctl_q[g][PC_SUPER_BIT] && mode_super)
			|| (pctl_q[g][PC_USER_BIT] && mode_user)
			|| (pctl_q[g][PC_EXL_BIT] && mode_exl);
		assign hit    = evts[pctl_q[g][PC_EVT_MSB:PC_EVT_LSB]] && qual;

		always_comb begin
			pctl_d[g] = pctl_q[g];
			pcnt_d[g] = pcnt_q[g];
			if (wr_ctl) begin
				pctl_d[g] = (pctl_q[g] & ~PC_WR_MASK) | (i_cop_wr_data[31:0] & PC_WR_MASK);
			end
			// A software write overrides an increment in the same cycle
			if (wr_cnt) begin
				pcnt_d[g] = i_cop_wr_data;
			end else if (hit) begin
				pcnt_d[g] = pcnt_q[g] + 64'h0000000000000001;
			end
		end

		always_ff @(posedge i_core_clk) begin
			if (!i_rst_n) begin
				pctl_q[g] <= (g == 0) ? PC0_RESET : PC1_RESET;
				pcnt_q[g] <= 64'h0000000000000000;
			end else begin
				pctl_q[g] <= pctl_d[g];
				pcnt_q[g] <= pcnt_d[g];
			end
		end
	end

	// Pending level stays until software rewrites the counter; the interrupt also drops when its enable is cleared
	always_comb begin
		o_perf_pending = pcnt_q[0][63] || pcnt_q[1][63];
		o_perf_irq     = (pcnt_q[0][63] && pctl_q[0][PC_IE_BIT])
			|| (pcnt_q[1][63] && pctl_q[1][PC_IE_BIT]);
	end

	// Read port: data registered one cycle after the request
	always_comb begin
		rd_d     = 64'h0000000000000000;
		rd_vld_d = i_cop_rd_en;
		if (i_cop_rd_en) begin
			case (i_cop_reg)
				REGN_FEATURE: rd_d = (i_cop_sel == SEL_FEATURE) ? {32'h00000000, feat} : '0;
				REGN_LINKED_LOAD_ADDRESS:  rd_d = (i_cop_sel == SEL_ZERO) ? ll_q : '0;
				REGN_CTX_EXT: rd_d = (i_cop_sel == SEL_ZERO) ? ctx_q : '0;
				REGN_DIAG:    rd_d = (i_cop_sel == SEL_ZERO) ? {57'h0, diag_q} : '0;
				REGN_DEBUG:   rd_d = (i_cop_sel == SEL_ZERO) ? {32'h00000000, dbg_view} : '0;
				REGN_DRET:    rd_d = (i_cop_sel == SEL_ZERO) ? dret_q : '0;
				REGN_PERF: begin
					case (i_cop_sel)
						3'h0:    rd_d = {32'h00000000, pctl_q[0]};
						3'h1:    rd_d = pcnt_q[0];
						3'h2:    rd_d = {32'h00000000, pctl_q[1]};
						3'h3:    rd_d = pcnt_q[1];
						default: rd_d = '0;
					endcase
				end
				default: rd_d = '0;
			endcase
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			rd_q     <= 64'h0000000000000000;
			rd_vld_q <= 1'b0;
		end else begin
			rd_q     <= rd_d;
			rd_vld_q <= rd_vld_d;
		end
	end

	assign o_cop_rd_data            = rd_q;
	assign o_cop_rd_valid           = rd_vld_q;
	assign o_itlb_flush             = itlb_flush_q;
	assign o_btb_flush              = btb_flush_q;
	assign o_ras_disable            = diag_q[DIAG_RAS_BIT];
	assign o_unlimit                = diag_q[DIAG_WCAC_BIT:DIAG_SFET_BIT];
	assign o_debug_mode_flag        = dbg_q[DBG_DM_BIT];
	assign o_single_step_enable     = dbg_q[DBG_SST_BIT];
	assign o_debug_loadstore_target = dbg_q[DBG_DEBUG_LOADSTORE_TARGET_BIT];
	assign o_count_run_in_debug     = dbg_q[DBG_CNTDM_BIT];

	// Writes to the capability register are accepted and dropped
	logic unused_feat_wr;
	assign unused_feat_wr = wr_feat;

endmodule

//--- cds_sysregs_monitor.sv
`timescale 1ns/1ps
module cds_sysregs_monitor
	import cds_pkg::*;
#(
	parameter bit COUNT_IN_DBG = 1'b1
) (
	// Clock and reset
	input wire logic        i_core_clk,
	input wire logic        i_rst_n,
	// Register port
	input wire logic        i_cop_wr_en,
	input wire logic        i_cop_rd_en,
	input wire logic [4:0]  i_cop_reg,
	input wire logic [2:0]  i_cop_sel,
	input wire logic [63:0] i_cop_wr_data,
	input wire logic [63:0] o_cop_rd_data,
	input wire logic        o_cop_rd_valid,
	// Debug events and controls
	input wire logic        i_dbg_exc,
	input wire logic        i_dbg_return,
	input wire logic        o_itlb_flush,
	input wire logic        o_btb_flush,
	input wire logic [3:0]  o_unlimit,
	input wire logic        o_debug_mode_flag,
	input wire logic        o_single_step_enable,
	input wire logic        o_count_run_in_debug,
	input wire logic        o_perf_irq,
	input wire logic        o_perf_pending
);
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_n);

	logic diag_wr;
	logic dbg_wr;
	assign diag_wr = i_cop_wr_en && i_cop_reg == REGN_DIAG && i_cop_sel == SEL_ZERO;
	assign dbg_wr  = i_cop_wr_en && i_cop_reg == REGN_DEBUG && i_cop_sel == SEL_ZERO;

	rd_answer_a: assert property (i_cop_rd_en |=> o_cop_rd_valid)
		else $error("read request not answered");
	rd_quiet_a: assert property (!i_cop_rd_en |=> !o_cop_rd_valid && o_cop_rd_data == '0)
		else $error("read data without request");
	itlb_pulse_a: assert property (o_itlb_flush == $past(diag_wr && i_cop_wr_data[DIAG_ITLB_BIT]))
		else $error("instruction table flush pulse wrong");
	btb_pulse_a: assert property (o_btb_flush == $past(diag_wr && i_cop_wr_data[DIAG_BTB_BIT]))
		else $error("branch buffer flush pulse wrong");
	unlimit_hold_a: assert property (!$past(diag_wr) |-> $stable(o_unlimit))
		else $error("unlimit bits moved without write");
	mode_enter_a: assert property ($rose(o_debug_mode_flag) |-> $past(i_dbg_exc))
		else $error("debug mode entered without exception");
	mode_leave_a: assert property ($fell(o_debug_mode_flag) |-> $past(i_dbg_return))
		else $error("debug mode left without return");
	sst_write_a: assert property ((dbg_wr && o_debug_mode_flag) |=>
		o_single_step_enable == $past(i_cop_wr_data[DBG_SST_BIT]))
		else $error("single step bit not written");
	sst_hold_a: assert property ($changed(o_single_step_enable) |-> $past(dbg_wr))
		else $error("single step bit moved without write");
	cnt_dbg_a: assert property (o_count_run_in_debug == COUNT_IN_DBG)
		else $error("count in debug flag wrong");
	irq_pend_a: assert property (o_perf_irq |-> o_perf_pending)
		else $error("counter interrupt without pending bit");
endmodule

bind cds_sysregs cds_sysregs_monitor #(.COUNT_IN_DBG(COUNT_IN_DBG)) cds_sysregs_monitor_inst (.*);

//--- cds_sysregs_test.sv
`timescale 1ns/1ps
module cds_sysregs_test;
	import cds_pkg::*;

	logic i_core_clk, i_rst_n, i_cop_wr_en, i_cop_rd_en, i_ll_valid, i_eret, i_tlb_exc;
	logic i_dbg_exc, i_dbg_precise, i_dbg_int, i_dbg_ibreak, i_dbg_dbreak, i_dbg_bp;
	logic i_dbg_sstep, i_exc_in_dbg, i_exc_dslot, i_dbg_return, i_exception_level;
	logic i_error_level, o_cop_rd_valid, o_itlb_flush, o_btb_flush, o_ras_disable;
	logic o_debug_mode_flag, o_single_step_enable, o_debug_loadstore_target;
	logic o_count_run_in_debug, o_perf_irq, o_perf_pending;
	logic [4:0]  i_cop_reg, i_exc_code, c;
	logic [2:0]  i_cop_sel;
	logic [1:0]  i_privilege_level;
	logic [3:0]  o_unlimit;
	logic [15:0] i_perf_event0, i_perf_event1;
	logic [63:0] i_cop_wr_data, i_ll_pfn, i_tlb_vaddr, i_exc_pc, o_cop_rd_data;
	logic [63:0] d, b, va, pc, e;
	int          miscompares, samples_checked, n, ev;
	// Processor states: kernel, supervisor, user, exception level, error level
	logic [1:0]  pv [5] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h0};
	logic        ex [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
	logic        er [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
	int          hit [5] = '{1, 2, 3, 0, 9};

	cds_sysregs cds_sysregs_inst (.*);

	initial begin
		i_core_clk = 1'b0;
		forever #12.5 i_core_clk = ~i_core_clk;
	end

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic finish_test();
		if (miscompares == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Requests rise at one falling edge and drop at the next, so tasks never overlap
	task automatic wr(input logic [4:0] r, input logic [2:0] s, input logic [63:0] v);
		@(negedge i_core_clk);
		i_cop_wr_en = 1'b1;
		i_cop_reg = r;
		i_cop_sel = s;
		i_cop_wr_data = v;
		@(negedge i_core_clk);
		i_cop_wr_en = 1'b0;
	endtask

	task automatic rd(input logic [4:0] r, input logic [2:0] s, output logic [63:0] v);
		@(negedge i_core_clk);
		i_cop_rd_en = 1'b1;
		i_cop_reg = r;
		i_cop_sel = s;
		@(negedge i_core_clk);
		chk(o_cop_rd_valid, 1'b1);
		v = o_cop_rd_data;
		i_cop_rd_en = 1'b0;
	endtask

	task automatic rchk(input logic [4:0] r, input logic [2:0] s, input logic [63:0] x);
		logic [63:0] v;
		rd(r, s, v);
		chk(v, x);
	endtask

	task automatic pulse(ref logic sig);
		@(negedge i_core_clk);
		sig = 1'b1;
		@(negedge i_core_clk);
		sig = 1'b0;
	endtask

	initial begin
		#(25ns * 5000);
		miscompares++;
		finish_test();
	end

	initial begin
		void'($urandom(32'hEBF1));
		{i_rst_n, i_cop_wr_en, i_cop_rd_en, i_ll_valid, i_eret, i_tlb_exc, i_dbg_exc} = '0;
		{i_dbg_int, i_dbg_ibreak, i_dbg_dbreak, i_dbg_bp, i_dbg_sstep, i_exc_in_dbg} = '0;
		{i_exc_dslot, i_dbg_return, i_exception_level, i_error_level} = '0;
		{i_cop_reg, i_exc_code, i_cop_sel, i_privilege_level} = '0;
		{i_perf_event0, i_perf_event1, i_cop_wr_data, i_ll_pfn, i_tlb_vaddr, i_exc_pc} = '0;
		i_dbg_precise = 1'b1;
		repeat (16) @(negedge i_core_clk);
		i_rst_n = 1'b1;
		rchk(REGN_DEBUG, SEL_ZERO, 64'h18000);
		chk(o_count_run_in_debug, DBG_RESET[DBG_CNTDM_BIT]);
		rchk(REGN_FEATURE, SEL_FEATURE, 64'hA0);
		rchk(5'h1F, SEL_ZERO, 64'h0);
		for (int s = 0; s < 4; s++) begin
			rchk(REGN_PERF, 3'(s), s == 0 ? 64'hC0000000 : s == 2 ? 64'h40000000 : 64'h0);
		end
		wr(REGN_PERF, 3'h0, '1);
		rchk(REGN_PERF, 3'h0, 64'hC00001FF);
		wr(REGN_PERF, 3'h2, '1);
		rchk(REGN_PERF, 3'h2, 64'h400001FF);
		wr(REGN_PERF, 3'h2, 64'h0);
		i_ll_pfn = {$urandom, $urandom};
		pulse(i_ll_valid);
		wr(REGN_LINKED_LOAD_ADDRESS, SEL_ZERO, '1);
		rchk(REGN_LINKED_LOAD_ADDRESS, SEL_ZERO, i_ll_pfn);
		pulse(i_eret);
		rchk(REGN_LINKED_LOAD_ADDRESS, SEL_ZERO, 64'h0);
		b = {$urandom, $urandom};
		wr(REGN_CTX_EXT, SEL_ZERO, b);
		for (int r = 0; r < 4; r++) begin
			va = {2'(r), 30'($urandom), $urandom};
			i_tlb_vaddr = va;
			pulse(i_tlb_exc);
			rchk(REGN_CTX_EXT, SEL_ZERO, {b[63:41], va[63:62], va[47:13], 4'h0});
		end
		d = 64'($urandom % 128);
		wr(REGN_DIAG, SEL_ZERO, d);
		chk({o_itlb_flush, o_btb_flush}, {d[2], d[1]});
		rchk(REGN_DIAG, SEL_ZERO, d & 64'h79);
		chk({o_unlimit, o_ras_disable}, {d[6:3], d[0]});
		for (int k = 0; k < 2; k++) begin
			c = 5'($urandom);
			pc = {$urandom, $urandom} | 64'h100;
			{i_dbg_int, i_dbg_ibreak, i_dbg_dbreak, i_dbg_bp, i_dbg_sstep} = c;
			i_exc_dslot = (k == 0);
			i_exc_pc = pc;
			// Second exception is imprecise, so the return address must keep the first capture
			i_dbg_precise = (k == 0);
			pulse(i_dbg_exc);
			chk(o_debug_mode_flag, 1'b1);
			e = 64'h42018000 | {c[4:2], 1'b0, c[1:0]} | (k == 0 ? 64'h80000000 : 64'h10000100);
			rchk(REGN_DEBUG, SEL_ZERO, e);
			va = (k == 0) ? pc - 64'h4 : va;
			rchk(REGN_DRET, SEL_ZERO, va);
			if (k == 0) begin
				wr(REGN_DEBUG, SEL_ZERO, '1);
				rchk(REGN_DEBUG, SEL_ZERO, e | 64'h10000100);
				chk({o_single_step_enable, o_debug_loadstore_target}, 2'h3);
			end else begin
				i_exc_code = 5'($urandom);
				pulse(i_exc_in_dbg);
				rd(REGN_DEBUG, SEL_ZERO, d);
				chk(d[14:10], i_exc_code);
			end
			pulse(i_dbg_return);
			rchk(REGN_DEBUG, SEL_ZERO, 64'h18000);
		end
		ev = $urandom % 16;
		n = 0;
		wr(REGN_PERF, 3'h0, 64'(ev * 32 + 18));
		repeat (40) begin
			@(negedge i_core_clk);
			i_perf_event0 = 16'($urandom);
			n += i_perf_event0[ev];
		end
		@(negedge i_core_clk);
		i_perf_event0 = '0;
		rchk(REGN_PERF, 3'h1, 64'(n));
		wr(REGN_PERF, 3'h1, 64'h7FFFFFFFFFFFFFFF);
		chk({o_perf_irq, o_perf_pending}, 2'h0);
		@(negedge i_core_clk);
		i_perf_event0 = 16'h1 << ev;
		@(negedge i_core_clk);
		i_perf_event0 = '0;
		chk({o_perf_irq, o_perf_pending}, 2'h3);
		wr(REGN_PERF, 3'h0, 64'h0);
		chk({o_perf_irq, o_perf_pending}, 2'h1);
		wr(REGN_PERF, 3'h1, 64'h0);
		n = 0;
		for (int m = 0; m < 4; m++) begin
			wr(REGN_PERF, 3'h2, 64'h1 << m);
			for (int s = 0; s < 5; s++) begin
				@(negedge i_core_clk);
				{i_privilege_level, i_exception_level, i_error_level} = {pv[s], ex[s], er[s]};
				i_perf_event1 = 16'($urandom) | 16'h1;
				n += (hit[s] == m);
				@(negedge i_core_clk);
				i_perf_event1 = '0;
			end
			rchk(REGN_PERF, 3'h3, 64'(n));
		end
		i_rst_n = 1'b0;
		repeat (2) @(negedge i_core_clk);
		i_rst_n = 1'b1;
		rchk(REGN_PERF, 3'h2, 64'h40000000);
		rchk(REGN_PERF, 3'h3, 64'h0);
		finish_test();
	end
endmodule
